// File: design/iife_pkg.sv
/*
 * Package for the isolated input sample front end: register indices,
 * field positions, reset values, timing constants and shared types.
 * Assumes a 250 MHz core clock and a register port carried by the
 * surrounding SPI slave.
 */
package iife_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [9:0]  GAIN_ADDR      = 10'h201;
    localparam logic [9:0]  PATH_CTRL_ADDR = 10'h202;
    localparam logic [9:0]  IRQ_MASK_ADDR  = 10'h203;
    localparam logic [9:0]  IRQ_STAT_ADDR  = 10'h204;
    localparam logic [9:0]  CTRL_ADDR      = 10'h205;
    localparam logic [9:0]  SAMPLE_ADDR    = 10'h206;
    localparam logic [9:0]  LOCK_ADDR      = 10'h207;

    // ****************************************************************
    // Fields and reset values
    // ****************************************************************
    localparam int          GAIN_LSB       = 0;
    localparam int          AVG_EN_BIT     = 0;
    localparam int          RATIO_LSB      = 1;
    localparam int          PIN_MODE_BIT   = 2;
    localparam int          RST_DONE_BIT   = 14;
    localparam int          READY_BIT      = 15;
    localparam logic [15:0] REG_RST        = 16'h0000;
    localparam logic [15:0] RST_DONE_VAL   = 16'h4000;
    localparam logic [15:0] LOCK_KEY       = 16'h5a5a; // Arbitrary key

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ      = 250;
    localparam int SAMPLE_NS    = 10000;   // 100 kSPS aggregate
    localparam int READY_HI_NS  = 1000;    // 1 us pulse
    localparam int SAMPLE_CYC   = SAMPLE_NS * CLK_MHZ / 1000;
    localparam int READY_HI_CYC = READY_HI_NS * CLK_MHZ / 1000;

    // Gain codes
    typedef enum logic [1:0] {
        IIFE_GAIN_X1  = 2'h0,
        IIFE_GAIN_X2  = 2'h1,
        IIFE_GAIN_X5  = 2'h2,
        IIFE_GAIN_X10 = 2'h3
    } iife_gain_e;

    // Register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [9:0]  addr;
        logic [15:0] wdata;
    } iife_req_s;

    // Converter sample with its channel
    typedef struct packed {
        logic       chan;
        logic [7:0] data;
    } iife_smp_s;

endpackage : iife_pkg

// File: design/iife_top.sv
/*
 * Digital front end: gain register, channel sequencer for the shared
 * converter, averaging decimator, sample-ready pulse on the shared pin
 * and the two state outputs.
 * Assumes an SPI slave outside presents single-cycle register requests
 * and that converter results arrive with i_adc_valid, synchronous.
 */
`timescale 1ns/1ps
module iife_top
    import iife_pkg::*;
#(
    parameter int SMP_W = 8
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    // Register port
    input  wire iife_req_s        i_req,
    output logic [15:0]           o_rdata,
    // Converter side
    input  wire logic [SMP_W-1:0] i_adc_data,
    input  wire logic             i_adc_valid,
    input  wire logic [1:0]       i_input_state,
    output logic                  o_adc_start,
    output logic                  o_adc_chan,
    output logic [1:0]            o_gain,
    // Sample stream and pins
    output logic [SMP_W-1:0]      o_smp_data,
    output logic                  o_smp_chan,
    output logic                  o_smp_valid,
    output logic                  o_first_state_output,
    output logic                  o_shared_out,
    output logic                  o_shared_oe
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [1:0]  gain_q, gain_d;
    logic [2:0]  path_q, path_d;
    logic [15:0] mask_q, mask_d;
    logic        pin_mode_q, pin_mode_d;
    logic        locked_q, locked_d;
    logic [15:0] rdata_q, rdata_d;
    logic [SMP_W-1:0] last_q, last_d;

    // Register writes and read mux
    always_comb begin
        gain_d     = gain_q;
        path_d     = path_q;
        mask_d     = mask_q;
        pin_mode_d = pin_mode_q;
        locked_d   = locked_q;
        rdata_d    = rdata_q;
        if (i_req.wr) begin
            if (i_req.addr == GAIN_ADDR) begin
                gain_d = i_req.wdata[GAIN_LSB +: 2];
            end else if (i_req.addr == PATH_CTRL_ADDR) begin
                path_d = i_req.wdata[2:0];
            end else if (i_req.addr == IRQ_MASK_ADDR) begin
                mask_d = i_req.wdata;
            end else if (i_req.addr == CTRL_ADDR) begin
                pin_mode_d = i_req.wdata[PIN_MODE_BIT];
            end else if (i_req.addr == LOCK_ADDR) begin
                locked_d = (i_req.wdata == LOCK_KEY);
            end
        end
        if (i_req.rd) begin
            if (i_req.addr == GAIN_ADDR) begin
                rdata_d = {14'h0000, gain_q};
            end else if (i_req.addr == PATH_CTRL_ADDR) begin
                rdata_d = {13'h0000, path_q};
            end else if (i_req.addr == IRQ_MASK_ADDR) begin
                rdata_d = mask_q;
            end else if (i_req.addr == IRQ_STAT_ADDR) begin
                // reset-done always set once out of reset
                rdata_d = RST_DONE_VAL;
            end else if (i_req.addr == CTRL_ADDR) begin
                rdata_d = {13'h0000, pin_mode_q, 2'h0};
            end else if (i_req.addr == SAMPLE_ADDR) begin
                rdata_d = {{(16-SMP_W){1'b0}}, last_q};
            end else if (i_req.addr == LOCK_ADDR) begin
                rdata_d = {15'h0000, locked_q};
            end else begin
                rdata_d = 16'h0000;   // Unmapped reads as zero
            end
        end
    end

    // gain and controls clear at reset
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gain_q     <= IIFE_GAIN_X1;
            path_q     <= 3'h0;
            mask_q     <= REG_RST;
            pin_mode_q <= 1'b0;
            locked_q   <= 1'b0;
            rdata_q    <= REG_RST;
        end else begin
            gain_q     <= gain_d;
            path_q     <= path_d;
            mask_q     <= mask_d;
            pin_mode_q <= pin_mode_d;
            locked_q   <= locked_d;
            rdata_q    <= rdata_d;
        end
    end

    // ****************************************************************
    // Sample sequencer
    // ****************************************************************
    logic [11:0] tick_q, tick_d;
    logic        chan_q, chan_d, start_q, start_d, pin_q, pin_d;
    logic        wrap;

    // one conversion every 10 us, channel alternates
    always_comb begin
        wrap    = (tick_q == 12'(SAMPLE_CYC - 1));
        tick_d  = wrap ? 12'h000 : tick_q + 12'h001;
        chan_d  = wrap ? ~chan_q : chan_q;
        start_d = wrap;
        // ready high for first 1 us of each period
        pin_d   = (tick_d < 12'(READY_HI_CYC));
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_q  <= 12'h000;
            chan_q  <= 1'b0;
            start_q <= 1'b0;
            pin_q   <= 1'b0;
        end else begin
            tick_q  <= tick_d;
            chan_q  <= chan_d;
            start_q <= start_d;
            pin_q   <= pin_d;
        end
    end

    // ****************************************************************
    // Decimator, one accumulator per channel
    // ****************************************************************
    logic [SMP_W+2:0] acc_q [2], acc_d [2];
    logic [2:0]       cnt_q [2], cnt_d [2];
    logic [SMP_W-1:0] out_q, out_d;
    logic             ov_q, ov_d, oc_q, oc_d;
    logic [1:0]       shift;
    logic [2:0]       last_cnt;
    logic [SMP_W+2:0] sum;
    logic             ch;

    // accumulate N, emit mean; ratio decode
    always_comb begin
        acc_d    = acc_q;
        cnt_d    = cnt_q;
        out_d    = out_q;
        ov_d     = 1'b0;
        oc_d     = oc_q;
        last_d   = last_q;
        ch       = chan_q;
        shift    = path_q[RATIO_LSB +: 2];
        last_cnt = 3'((4'h1 << shift) - 4'h1);
        sum      = acc_q[ch] + (SMP_W+3)'(i_adc_data);
        if (i_adc_valid) begin
            // bypass unless enabled with nonzero ratio
            if (!path_q[AVG_EN_BIT] || shift == 2'h0) begin
                out_d = i_adc_data;
                ov_d  = 1'b1;
                oc_d  = ch;
            end else if (cnt_q[ch] == last_cnt) begin
                out_d     = SMP_W'(sum >> shift);
                ov_d      = 1'b1;
                oc_d      = ch;
                acc_d[ch] = '0;
                cnt_d[ch] = 3'h0;
            end else begin
                acc_d[ch] = sum;
                cnt_d[ch] = cnt_q[ch] + 3'h1;
            end
            last_d = ov_d ? out_d : last_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_q  <= '{default: '0};
            cnt_q  <= '{default: '0};
            out_q  <= '0;
            ov_q   <= 1'b0;
            oc_q   <= 1'b0;
            last_q <= '0;
        end else begin
            acc_q  <= acc_d;
            cnt_q  <= cnt_d;
            out_q  <= out_d;
            ov_q   <= ov_d;
            oc_q   <= oc_d;
            last_q <= last_d;
        end
    end

    // ****************************************************************
    // Output pins
    // ****************************************************************
    logic [1:0] st_q;
    logic       sh_q, oe_q;

    // input copy, or open-drain ready; pull-up gives high
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= 2'h0;
            sh_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            st_q <= i_input_state;
            sh_q <= pin_mode_q ? 1'b0 : i_input_state[1];
            oe_q <= pin_mode_q ? (mask_q[READY_BIT] & ~pin_d) : 1'b1;
        end
    end

    assign o_rdata              = rdata_q;
    assign o_adc_start          = start_q;
    assign o_adc_chan           = chan_q;
    assign o_gain               = gain_q;
    assign o_smp_data           = out_q;
    assign o_smp_chan           = oc_q;
    assign o_smp_valid          = ov_q;
    assign o_first_state_output = st_q[0];
    assign o_shared_out         = sh_q;
    assign o_shared_oe          = oe_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_wrap;
        tick_q == 12'(SAMPLE_CYC - 1);
    endsequence

    AST_GAIN_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_req.wr && i_req.addr == GAIN_ADDR) |=>
        gain_q == $past(i_req.wdata[1:0]))
        else $error("gain not taken from write");

    AST_CHAN_ALT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_wrap |=> (chan_q != $past(chan_q)) && start_q)
        else $error("channel did not alternate");

    AST_PERIOD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        start_q |=> !start_q [*8])
        else $error("conversions too close");

    AST_PIN_HIGH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (tick_q == 12'h000) |=> pin_q)
        else $error("ready not high at period start");

    AST_PIN_LOW: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (tick_q == 12'(READY_HI_CYC)) |=> !pin_q)
        else $error("ready not low after 1 us");

    AST_BYPASS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_adc_valid && !path_q[AVG_EN_BIT]) |=>
        ov_q && out_q == $past(i_adc_data))
        else $error("bypass sample changed");

    AST_AVG_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_adc_valid && path_q[AVG_EN_BIT] && shift != 2'h0
         && cnt_q[ch] != last_cnt) |=> !ov_q)
        else $error("output before group complete");

    AST_STATE_OUT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        1'b1 |=> o_first_state_output == $past(i_input_state[0]))
        else $error("state output lags input");

endmodule : iife_top

// File: tb/iife_host_model.sv
/*
 * Host controller model: drives the register port of the front end
 * the way the host behind the serial port would.
 * Assumes the block takes requests on the rising edge and answers a
 * read one cycle later; requests change at the falling edge.
 */
`timescale 1ns/1ps
module iife_host_model
    import iife_pkg::*;
(
    // Clock and read data
    input  wire logic        i_clk,
    input  wire logic [15:0] i_rdata,
    // Request
    output iife_req_s        o_req
);
    // Idle port until the first access
    initial o_req = '0;

    // One write, held across one rising edge
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(negedge i_clk);
        o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge i_clk);
        o_req = '0;
    endtask : wr

    // One read; data is taken a cycle and a half after the request edge
    task automatic rd(input logic [9:0] a, output logic [15:0] d);
        @(negedge i_clk);
        o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge i_clk);
        o_req = '0;
        @(negedge i_clk);
        d = i_rdata;
    endtask : rd

    // Power-up order; polling is bounded so a dead part cannot hang us
    task automatic startup(input logic [1:0] g);
        logic [15:0] s;
        s = 16'h0000;
        for (int i = 0; i < 16 && s[RST_DONE_BIT] !== 1'b1; i++) begin
            rd(IRQ_STAT_ADDR, s);
        end
        wr(GAIN_ADDR, {14'h0000, g});
        wr(PATH_CTRL_ADDR, 16'h0000);
        wr(LOCK_ADDR, LOCK_KEY);
    endtask : startup

    task automatic irq_on;
        wr(CTRL_ADDR, 16'h0004);
        wr(IRQ_MASK_ADDR, 16'h8000);
    endtask : irq_on
endmodule : iife_host_model

// File: tb/tb_iife_top.sv
/*
 * Self-checking bench for the front end top.
 * Assumes the host model above on the register port and drives the
 * converter results and input states itself at the falling edge.
 */
`timescale 1ns/1ps
module tb_iife_top;
    import iife_pkg::*;
    logic        i_clk   = 1'b0;
    logic        i_rst_n = 1'b0;
    iife_req_s   req;
    logic [15:0] rdata, v;
    logic [7:0]  adc_d = 8'h00, smp_d, last_d;
    logic        adc_v = 1'b0;
    logic [1:0]  in_st = 2'h0, gain;
    logic        start, chan, smp_c, smp_v, st1, sh_o, sh_oe, c0;
    int          errors = 0, check_count = 0, nval = 0, n, sum, nbase;

    // 250 MHz clock
    always #2 i_clk = ~i_clk;

    iife_top iife_top_i (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req), .o_rdata(rdata),
        .i_adc_data(adc_d), .i_adc_valid(adc_v), .i_input_state(in_st),
        .o_adc_start(start), .o_adc_chan(chan), .o_gain(gain),
        .o_smp_data(smp_d), .o_smp_chan(smp_c), .o_smp_valid(smp_v),
        .o_first_state_output(st1), .o_shared_out(sh_o),
        .o_shared_oe(sh_oe));
    iife_host_model iife_host_model_i (
        .i_clk(i_clk), .i_rdata(rdata), .o_req(req));

    // Count stream results; averaging must give one per group
    always @(posedge i_clk) if (smp_v === 1'b1) begin
        nval   <= nval + 1;
        last_d <= smp_d;
    end

    task automatic report_and_stop;
        $display("Checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Cycles until a level shows; 0 start pulse, 1 ready on the pin
    task automatic wait_lvl(input int w, input logic lv, output int k);
        logic s;
        k = 0;
        do begin
            @(negedge i_clk);
            k++;
            // Released open-drain pin reads high through its pull-up
            s = (w == 0) ? start : (sh_oe ? sh_o : 1'b1);
        end while (s !== lv && k < 3000);
        if (k >= 3000) begin
            chk("wait_bound", 16'h0000, 16'h0001);
            report_and_stop();
        end
    endtask : wait_lvl

    task automatic adc(input logic [7:0] d);
        @(negedge i_clk);
        adc_d = d;
        adc_v = 1'b1;
        @(negedge i_clk);
        adc_v = 1'b0;
    endtask : adc

    task automatic t_reset;
        iife_host_model_i.rd(IRQ_STAT_ADDR, v);
        chk("reset_done", 16'h0001, {15'h0, v[RST_DONE_BIT]});
        iife_host_model_i.rd(GAIN_ADDR, v);
        chk("gain_reset", 16'h0000, v);
        iife_host_model_i.rd(10'h3ff, v);
        chk("unmapped", 16'h0000, v);
        iife_host_model_i.startup(2'h0);
        iife_host_model_i.rd(LOCK_ADDR, v);
        chk("locked", 16'h0001, {15'h0, v[0]});
    endtask : t_reset

    task automatic t_gain;
        for (int g = 3; g >= 0; g--) begin
            iife_host_model_i.wr(GAIN_ADDR, 16'hfffc | 16'(g));
            @(negedge i_clk);
            chk("o_gain", 16'(g), {14'h0, gain});
            iife_host_model_i.rd(GAIN_ADDR, v);
            chk("gain_rd", 16'(g), {14'h0, v[1:0]});
        end
    endtask : t_gain

    // Each ratio code, group sent on one channel after a start pulse
    task automatic t_avg;
        for (int r = 0; r < 4; r++) begin
            iife_host_model_i.wr(PATH_CTRL_ADDR, 16'(r * 2 + 1));
            wait_lvl(0, 1'b1, n);
            nbase = nval;
            sum   = 0;
            for (int i = 0; i < (1 << r); i++) begin
                sum += 16 + 8 * i + r;
                adc(8'(16 + 8 * i + r));
            end
            repeat (2) @(negedge i_clk);
            chk("groups", 16'h0001, 16'(nval - nbase));
            chk("mean", 16'(sum >> r), {8'h0, last_d});
            chk("smp_chan", {15'h0, chan}, {15'h0, smp_c});
        end
        iife_host_model_i.wr(PATH_CTRL_ADDR, 16'h0006);
        nbase = nval;
        adc(8'h5c);
        adc(8'ha3);
        repeat (2) @(negedge i_clk);
        chk("bypass_n", 16'h0002, 16'(nval - nbase));
        chk("bypass_d", 16'h00a3, {8'h0, last_d});
        iife_host_model_i.rd(SAMPLE_ADDR, v);
        chk("last_rd", 16'h00a3, v);
    endtask : t_avg

    task automatic t_state;
        for (int s = 0; s < 4; s++) begin
            in_st = 2'(s);
            repeat (3) @(negedge i_clk);
            chk("out1", 16'(s & 1), {15'h0, st1});
            chk("out2", 16'(s >> 1), {15'h0, sh_o});
            chk("out2_oe", 16'h0001, {15'h0, sh_oe});
        end
    endtask : t_state

    task automatic t_seq;
        wait_lvl(0, 1'b1, n);
        c0 = chan;
        wait_lvl(0, 1'b1, n);
        chk("period", 16'(SAMPLE_CYC), 16'(n));
        chk("chan_alt", {15'h0, ~c0}, {15'h0, chan});
        iife_host_model_i.irq_on();
        // Line up on a full rising edge of the ready phase first
        wait_lvl(1, 1'b0, n);
        wait_lvl(1, 1'b1, n);
        wait_lvl(1, 1'b0, n);
        chk("ready_hi", 16'(READY_HI_CYC), 16'(n));
        wait_lvl(1, 1'b1, n);
        chk("ready_lo", 16'(SAMPLE_CYC - READY_HI_CYC), 16'(n));
    endtask : t_seq

    initial begin
        repeat (8) @(negedge i_clk);
        i_rst_n = 1'b1;
        t_reset();
        $display("Done reset");
        t_gain();
        $display("Done gain");
        t_avg();
        $display("Done averaging");
        t_state();
        $display("Done state");
        t_seq();
        $display("Done sequencer");
        report_and_stop();
    end
endmodule : tb_iife_top
